// >>> hdl/rtcpw_defs.svh
`ifndef RTCPW_DEFS_SVH
`define RTCPW_DEFS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define RTCPW_ADDR_W 8
`define RTCPW_ADDR_STATUS 8'h00
`define RTCPW_ADDR_CONFIG 8'h04
`define RTCPW_ADDR_PWIN 8'h08
`define RTCPW_ADDR_SECS 8'h0C
`define RTCPW_ADDR_ALARM 8'h10
`define RTCPW_ADDR_IRQ_STAT 8'h14
`define RTCPW_ADDR_IRQ_MASK 8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTCPW_ST_HALF 0
`define RTCPW_ST_BUSY 1
`define RTCPW_ST_TS 3
`define RTCPW_ST_ALM 5
`define RTCPW_CFG_PWC_EN 0
`define RTCPW_CFG_TS_EN 1
`define RTCPW_CFG_PS_LO 6
`define RTCPW_CFG_PS_HI 7
`define RTCPW_IRQ_TS 0
`define RTCPW_IRQ_ALM 1

// ----------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------
`define RTCPW_PS_DIV1 2'h0
`define RTCPW_PS_DIV16 2'h1
`define RTCPW_PS_DIV64 2'h2
`define RTCPW_PS_DIV256 2'h3
`define RTCPW_TERM_DIV1 8'h00
`define RTCPW_TERM_DIV16 8'h0F
`define RTCPW_TERM_DIV64 8'h3F
`define RTCPW_TERM_DIV256 8'hFF
`define RTCPW_LEN_OFF 8'h00
`define RTCPW_LEN_ALWAYS 8'hFF
`define RTCPW_SEC_UNITS_MAX 4'h9
`define RTCPW_RESP_OKAY 2'h0
`define RTCPW_RESP_SLVERR 2'h2
`define RTCPW_RST16 16'h0000
`define RTCPW_RST2 2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RTCPW_CLK_PERIOD_NS 100
`define RTCPW_HALF_SEC_NS 500000000
`define RTCPW_ALM_GUARD_NS 10000

`endif

// >>> hdl/rtcpw_pkg.sv
package rtcpw_pkg;

    // power window sequencer states
    typedef enum logic [2:0] {
        RTCPW_IDLE = 3'h1,
        RTCPW_STAB = 3'h2,
        RTCPW_SAMP = 3'h4
    } rtcpw_state_t;

    // power window configuration word
    typedef struct packed {
        logic [7:0] samp_len;
        logic [7:0] stab_len;
    } rtcpw_win_cfg_t;

    // alarm control word
    typedef struct packed {
        logic enable;
        logic [2:0] pad;
        logic [3:0] mask;
        logic [7:0] repeat_cnt;
    } rtcpw_alarm_t;

endpackage : rtcpw_pkg

// >>> hdl/rtcpw_window.sv
`timescale 1ns/1ns
`include "rtcpw_defs.svh"

module rtcpw_window (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clr,
    input wire logic start,
    input wire logic tick,
    input wire logic [7:0] len,
    output logic active
);

    logic [7:0] count;
    logic [7:0] next_count;

    // load on start, count down one per prescaled tick
    always_comb begin
        next_count = count;
        if (clr) begin
            next_count = `RTCPW_LEN_OFF;
        end else if (start) begin
            next_count = len;
        end else if (tick && count != `RTCPW_LEN_OFF) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= `RTCPW_LEN_OFF;
        end else begin
            count <= next_count;
        end
    end

    // a zero length leaves the window inactive
    assign active = (count != `RTCPW_LEN_OFF);

endmodule : rtcpw_window

// >>> hdl/rtcpw_top.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rtcpw_defs.svh"

// How it works
// [R1] timestamp event flag sits in status bit 3, set after a capture
// [R2] writing one to bit 3 starts a software capture; flag marks done
// [R3] alarm busy high: alarm setting writes are dropped, hardware may edit
// [R4] alarm busy low: alarm writes are taken intact
// [R5] half-second phase is read-only, cleared by any seconds-units write
// [R6] sample length bits 15:8, stability length bits 7:0 of window config
// [R7] each window spans 0 to 255 prescaled power-control clock periods
// [R8] two-bit prescale at config bits 7:6 divides by 1, 16, 64, 256
// [R9] a zero length keeps its window inactive
// [R10] stability length all ones keeps stability window always on
// [R11] alarm event flag in status bit 5, set on alarm, software clears
// [R12] while timestamp flag is set, every further capture is refused
// [R13] writing zero clears a flag; zero to a clear flag does nothing
module rtcpw_top
    import rtcpw_pkg::*;
#(
    parameter int HALF_SEC_CYCLES = `RTCPW_HALF_SEC_NS / `RTCPW_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tamper_n,
    input wire logic alarm_match,
    output logic ts_capture,
    output logic stability_window,
    output logic sample_window,
    output logic irq
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam int GUARD_CYCLES =
        (`RTCPW_ALM_GUARD_NS + `RTCPW_CLK_PERIOD_NS - 1)
        / `RTCPW_CLK_PERIOD_NS;
    localparam logic [22:0] HALF_LAST = 23'(HALF_SEC_CYCLES - 1);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == `RTCPW_ADDR_STATUS) ||
                    (addr == `RTCPW_ADDR_CONFIG) ||
                    (addr == `RTCPW_ADDR_PWIN) ||
                    (addr == `RTCPW_ADDR_SECS) ||
                    (addr == `RTCPW_ADDR_ALARM) ||
                    (addr == `RTCPW_ADDR_IRQ_STAT) ||
                    (addr == `RTCPW_ADDR_IRQ_MASK);
    endfunction : is_mapped

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) merge16[7:0] = data[7:0];
        if (strb[1]) merge16[15:8] = data[15:8];
    endfunction : merge16

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [15:0] config_reg, next_config_reg;
    rtcpw_win_cfg_t win_cfg, next_win_cfg;
    rtcpw_alarm_t alarm_cfg, next_alarm_cfg;
    logic [3:0] seconds_units, next_seconds_units;
    logic timestamp_event_flag, next_timestamp_event_flag;
    logic alarm_event_flag, next_alarm_event_flag;
    logic [1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
    logic ts_pulse, next_ts_pulse;
    logic half_second_phase, next_half_second_phase;
    logic [22:0] half_cnt, next_half_cnt;
    logic tamper_meta, tamper_sync, tamper_prev;
    logic [7:0] pre_cnt, next_pre_cnt;
    rtcpw_state_t state, next_state;
    logic do_write, do_read, sec_tick, alarm_update_busy;
    logic ts_hw, ts_sw, ts_req, alarm_hit, win_tick;
    logic [7:0] pre_term;
    logic [1:0] win_clr, win_start, win_active;
    logic [7:0] win_len [2];
    logic [15:0] status_word;

    // ------------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------------
    // one write and one read in flight; address and data in any order
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign do_write = aw_held && w_held && !bvalid;
    assign do_read = s_axi_arvalid && !rvalid;

    // ------------------------------------------------------------------
    // time base and alarm guard
    // ------------------------------------------------------------------
    assign sec_tick = half_second_phase && (half_cnt == HALF_LAST);
    // busy just before the second rolls, when alarm control may change
    assign alarm_update_busy = half_second_phase &&
        (32'(half_cnt) + GUARD_CYCLES >= HALF_SEC_CYCLES); // [R3]
    assign alarm_hit = sec_tick && alarm_cfg.enable && alarm_match;

    // ------------------------------------------------------------------
    // timestamp triggers
    // ------------------------------------------------------------------
    assign ts_hw = tamper_prev && !tamper_sync;
    assign ts_sw = do_write && (aw_addr == `RTCPW_ADDR_STATUS) &&
                   w_strb[0] && w_data[`RTCPW_ST_TS]; // [R2]
    // a pending or finished capture blocks any new one
    assign ts_req = config_reg[`RTCPW_CFG_TS_EN] && (ts_hw || ts_sw) &&
                    !timestamp_event_flag && !ts_pulse; // [R12]

    // status word as software sees it; sync bit reads zero
    assign status_word = {10'h000, alarm_event_flag, 1'b0,
                          timestamp_event_flag, 1'b0,
                          alarm_update_busy, half_second_phase};

    // ------------------------------------------------------------------
    // bus channel next state
    // ------------------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr) ? `RTCPW_RESP_OKAY
                                            : `RTCPW_RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(s_axi_araddr) ? `RTCPW_RESP_OKAY
                                                 : `RTCPW_RESP_SLVERR;
            unique case (s_axi_araddr)
                `RTCPW_ADDR_STATUS: next_rdata = {16'h0000, status_word};
                `RTCPW_ADDR_CONFIG: next_rdata = {16'h0000, config_reg};
                `RTCPW_ADDR_PWIN: next_rdata = {16'h0000, win_cfg};
                `RTCPW_ADDR_SECS: next_rdata = {28'h0000000, seconds_units};
                `RTCPW_ADDR_ALARM: next_rdata = {16'h0000, alarm_cfg};
                `RTCPW_ADDR_IRQ_STAT: next_rdata = {30'h00000000, irq_status};
                `RTCPW_ADDR_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RTCPW_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `RTCPW_RESP_OKAY;
            rdata <= 32'h00000000;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // software registers, flags and time base
    // ------------------------------------------------------------------
    // hardware sets are applied after software clears so the set wins
    always_comb begin
        next_config_reg = config_reg;
        next_win_cfg = win_cfg;
        next_alarm_cfg = alarm_cfg;
        next_seconds_units = seconds_units;
        next_timestamp_event_flag = timestamp_event_flag;
        next_alarm_event_flag = alarm_event_flag;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_ts_pulse = ts_req;
        next_half_cnt = half_cnt + 23'h000001;
        next_half_second_phase = half_second_phase;
        if (half_cnt == HALF_LAST) begin
            next_half_cnt = 23'h000000;
            next_half_second_phase = !half_second_phase;
        end
        if (sec_tick) begin
            next_seconds_units = (seconds_units == `RTCPW_SEC_UNITS_MAX)
                ? 4'h0 : seconds_units + 4'h1;
        end
        // repeat count and enable change under hardware at the second
        if (alarm_hit) begin
            if (alarm_cfg.repeat_cnt == 8'h00) begin
                next_alarm_cfg.enable = 1'b0;
            end else begin
                next_alarm_cfg.repeat_cnt = alarm_cfg.repeat_cnt - 8'h01;
            end
        end
        if (do_read && s_axi_araddr == `RTCPW_ADDR_IRQ_STAT) begin
            next_irq_status = 2'h0;
        end
        if (do_write) begin
            unique case (aw_addr)
                `RTCPW_ADDR_STATUS: begin
                    if (w_strb[0] && !w_data[`RTCPW_ST_TS]) begin
                        next_timestamp_event_flag = 1'b0; // [R13]
                    end
                    if (w_strb[0] && !w_data[`RTCPW_ST_ALM]) begin
                        next_alarm_event_flag = 1'b0; // [R11] [R13]
                    end
                end
                `RTCPW_ADDR_CONFIG:
                    next_config_reg = merge16(config_reg, w_data, w_strb);
                `RTCPW_ADDR_PWIN:
                    next_win_cfg = merge16(win_cfg, w_data, w_strb); // [R6]
                `RTCPW_ADDR_SECS: begin
                    if (w_strb[0]) begin
                        next_seconds_units = w_data[3:0];
                        next_half_second_phase = 1'b0; // [R5]
                        next_half_cnt = 23'h000000;
                    end
                end
                `RTCPW_ADDR_ALARM: begin
                    // dropped while busy so a half-made edit cannot land
                    if (!alarm_update_busy) begin // [R3] [R4]
                        next_alarm_cfg = merge16(alarm_cfg, w_data, w_strb);
                        next_alarm_cfg.pad = 3'h0;
                    end
                end
                `RTCPW_ADDR_IRQ_MASK: begin
                    if (w_strb[0]) next_irq_mask = w_data[1:0];
                end
                default: begin
                end
            endcase
        end
        if (ts_pulse) begin
            next_timestamp_event_flag = 1'b1; // [R1] [R2]
            next_irq_status[`RTCPW_IRQ_TS] = 1'b1;
        end
        if (alarm_hit) begin
            next_alarm_event_flag = 1'b1; // [R11]
            next_irq_status[`RTCPW_IRQ_ALM] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= `RTCPW_RST16;
            win_cfg <= `RTCPW_RST16;
            alarm_cfg <= `RTCPW_RST16;
            seconds_units <= 4'h0;
            timestamp_event_flag <= 1'b0;
            alarm_event_flag <= 1'b0;
            irq_status <= `RTCPW_RST2;
            irq_mask <= `RTCPW_RST2;
            ts_pulse <= 1'b0;
            half_cnt <= 23'h000000;
            half_second_phase <= 1'b0;
        end else begin
            config_reg <= next_config_reg;
            win_cfg <= next_win_cfg;
            alarm_cfg <= next_alarm_cfg;
            seconds_units <= next_seconds_units;
            timestamp_event_flag <= next_timestamp_event_flag;
            alarm_event_flag <= next_alarm_event_flag;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            ts_pulse <= next_ts_pulse;
            half_cnt <= next_half_cnt;
            half_second_phase <= next_half_second_phase;
        end
    end

    // tamper pin synchroniser; the second and third stages feed the edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tamper_meta <= 1'b1;
            tamper_sync <= 1'b1;
            tamper_prev <= 1'b1;
        end else begin
            tamper_meta <= tamper_n;
            tamper_sync <= tamper_meta;
            tamper_prev <= tamper_sync;
        end
    end

    // ------------------------------------------------------------------
    // power window prescaler and sequencer
    // ------------------------------------------------------------------
    always_comb begin
        unique case (config_reg[`RTCPW_CFG_PS_HI:`RTCPW_CFG_PS_LO]) // [R8]
            `RTCPW_PS_DIV1: pre_term = `RTCPW_TERM_DIV1;
            `RTCPW_PS_DIV16: pre_term = `RTCPW_TERM_DIV16;
            `RTCPW_PS_DIV64: pre_term = `RTCPW_TERM_DIV64;
            `RTCPW_PS_DIV256: pre_term = `RTCPW_TERM_DIV256;
        endcase
    end

    // restarts with each window so no period is cut short
    assign win_tick = (pre_cnt >= pre_term); // [R7]
    assign next_pre_cnt = (win_tick || |win_start) ? 8'h00 : pre_cnt + 8'h01;

    // stability window then sample window, repeating while enabled
    always_comb begin
        next_state = state;
        win_start = 2'h0;
        win_clr = 2'h0;
        unique case (state)
            RTCPW_IDLE: begin
                if (config_reg[`RTCPW_CFG_PWC_EN]) begin
                    win_start[0] = 1'b1;
                    next_state = RTCPW_STAB;
                end
            end
            RTCPW_STAB: begin
                if (!win_active[0]) begin
                    win_start[1] = 1'b1;
                    next_state = RTCPW_SAMP;
                end
            end
            RTCPW_SAMP: begin
                if (!win_active[1]) begin
                    next_state = RTCPW_IDLE;
                end
            end
        endcase
        if (!config_reg[`RTCPW_CFG_PWC_EN]) begin
            next_state = RTCPW_IDLE;
            win_clr = 2'h3;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= RTCPW_IDLE;
            pre_cnt <= 8'h00;
        end else begin
            state <= next_state;
            pre_cnt <= next_pre_cnt;
        end
    end

    assign win_len[0] = win_cfg.stab_len;
    assign win_len[1] = win_cfg.samp_len;

    // one down-counter per window; zero length stays inactive
    for (genvar i = 0; i < 2; i++) begin : g_win
        rtcpw_window u_win (
            .clk(clk),
            .resetn(resetn),
            .clr(win_clr[i]),
            .start(win_start[i]),
            .tick(win_tick),
            .len(win_len[i]),
            .active(win_active[i]) // [R9]
        );
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign stability_window = win_active[0] ||
        (win_cfg.stab_len == `RTCPW_LEN_ALWAYS); // [R10]
    assign sample_window = win_active[1]; // [R9]
    assign ts_capture = ts_pulse;
    assign irq = |(irq_status & irq_mask);

endmodule : rtcpw_top

// >>> verification/rtcpw_top_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------
// bus, capture and window checks
// ----------------------------------------
module rtcpw_chk #(
    parameter int HALF_SEC_CYCLES = 200
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic ts_capture,
    input wire logic stability_window,
    input wire logic sample_window
);
    // single domain, so one clock and reset serve all
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // both write channels taken at one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // no second capture in the three cycles after one
    sequence s_quiet;
        !ts_capture [*3];
    endsequence
    property p_wr_resp;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block)
        else $error("write ready during response");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response missing");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block)
        else $error("read ready during response");
    property p_bresp;
        s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2};
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("bad write response code");
    property p_rresp;
        s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2};
    endproperty
    a_rresp: assert property (p_rresp)
        else $error("bad read response code");
    property p_ts_once;
        ts_capture |=> s_quiet;
    endproperty
    a_ts_once: assert property (p_ts_once)
        else $error("capture repeated");
    property p_samp_follows;
        $rose(sample_window) |-> $past(stability_window, 2) ||
            !$past(stability_window);
    endproperty
    a_samp_follows: assert property (p_samp_follows)
        else $error("sample window out of order");
endmodule : rtcpw_chk

bind rtcpw_top rtcpw_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES))
    i_rtcpw_chk (.*);

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk, resetn, tamper_n, alarm_match, ts_capture, irq;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, stability_window, sample_window;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fail_count, checked, pulses, ns, np;
    int dv[4] = '{1, 16, 64, 256};
    // short half second keeps the run brief
    rtcpw_top #(.HALF_SEC_CYCLES(200)) i_rtcpw_top (.*);
    // ----------------------------------------
    // clock, pulse count, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (ts_capture) pulses++;
    initial begin
        #5000000;
        fail_count++;
        end_sim;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task end_sim;
        $display("mismatches %0d checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // handshakes sampled on the falling edge, driven on the rising
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(negedge clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end while (!b);
    endtask : wr
    task rd(input logic [7:0] a);
        logic ar, v;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(negedge clk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'h0;
        end while (!v);
    endtask : rd
    task poll(input logic [31:0] m);
        do rd(8'h00); while ((d & m) !== m);
    endtask : poll
    // one stability window, then the sample window
    task meas;
        @(posedge clk iff !stability_window);
        @(posedge clk iff stability_window);
        ns = 0;
        np = 0;
        while (stability_window) begin
            ns++;
            @(posedge clk);
        end
        @(posedge clk iff sample_window);
        while (sample_window) begin
            np++;
            @(posedge clk);
        end
    endtask : meas
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {tamper_n, s_axi_bready, s_axi_rready, alarm_match} = 4'hE;
        {s_axi_wstrb, s_axi_awaddr, s_axi_araddr} = 20'hF0000;
        s_axi_wdata = 32'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        rd(8'h00);
        chk(d, 32'h0);
        rd(8'h1C);
        chk({d[29:0], r}, 32'h2);
        wr(8'h18, 32'h1);
        wr(8'h04, 32'h2);
        chk(r, 32'h0);
        wr(8'h00, 32'h8);
        rd(8'h00);
        chk(d & 32'h28, 32'h8);
        chk(32'(irq), 32'h1);
        wr(8'h00, 32'h8);
        chk(pulses, 32'h1);
        rd(8'h14);
        chk(d, 32'h1);
        chk(32'(irq), 32'h0);
        // clearing an already clear flag leaves it clear
        repeat (2) begin
            wr(8'h00, 32'h0);
            rd(8'h00);
            chk(d & 32'h28, 32'h0);
        end
        // masked tamper event: flag set, interrupt held back
        wr(8'h18, 32'h0);
        tamper_n <= 1'h0;
        repeat (6) @(posedge clk);
        tamper_n <= 1'h1;
        rd(8'h00);
        chk(d & 32'h28, 32'h8);
        chk(32'(irq), 32'h0);
        wr(8'h18, 32'h1);
        chk(32'(irq), 32'h1);
        wr(8'h00, 32'h0);
        poll(32'h1);
        wr(8'h0C, 32'h5);
        rd(8'h00);
        chk(d & 32'h1, 32'h0);
        wr(8'h10, 32'h8F05);
        rd(8'h10);
        chk(d, 32'h8F05);
        poll(32'h2);
        wr(8'h10, 32'h0A00);
        rd(8'h10);
        chk(d, 32'h8F05);
        alarm_match <= 1'h1;
        poll(32'h20);
        alarm_match <= 1'h0;
        rd(8'h10);
        chk(d, 32'h8F04);
        wr(8'h08, 32'h0102);
        for (int p = 0; p < 4; p++) begin
            wr(8'h04, {24'h0, p[1:0], 6'h1});
            meas;
            chk(ns, 2 * dv[p]);
            chk(np, dv[p]);
        end
        wr(8'h04, 32'h1);
        wr(8'h08, 32'hFF01);
        meas;
        chk(np, 255);
        wr(8'h08, 32'h0);
        repeat (300) @(posedge clk);
        chk({stability_window, sample_window}, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h00FF);
        chk({stability_window, sample_window}, 32'h2);
        end_sim;
    end
endmodule : tb
